// File: bus_partner.sv
// far-side memory model answering on the multiplexed bus
module bus_partner (
	// clock
	input  wire logic               sys_clk,
	// pins seen from the device
	input  wire cpu_pin_pkg::data_t sharedAdOut,
	input  wire logic               addrStrobe,
	input  wire logic               slow,
	// answers
	output cpu_pin_pkg::data_t      sharedAdIn,
	output logic                    busReady
);
	timeunit 1ns;
	timeprecision 1ns;
	import cpu_pin_pkg::*;
	data_t      addr_reg = 16'h0000;
	logic       busy_reg = 1'b0;
	logic [1:0] cnt_reg  = 2'h0;
	always_ff @(posedge sys_clk) begin
		if (addrStrobe) begin
			addr_reg <= sharedAdOut;
			busy_reg <= 1'b1;
			cnt_reg  <= slow ? 2'h2 : 2'h0;
		end else if (busy_reg) begin
			if (cnt_reg == 2'h0)
				busy_reg <= 1'b0;
			else
				cnt_reg <= cnt_reg - 2'h1;
		end
	end
	assign busReady   = busy_reg && cnt_reg == 2'h0;
	// released bus shows the inverse, so a stale value never reads as good
	assign sharedAdIn = busy_reg ? addr_reg ^ 16'hA5C3 : ~(addr_reg ^ 16'hA5C3);
endmodule

// File: bus_phase_if.sv
// phase handshake between the pin controller and the bus phase sequencer
interface bus_phase_if;
	logic start;
	logic ready;
	logic holdReq;
	logic allow;
	logic addrPhase;
	logic dataPhase;
	logic cycleDone;
	logic holdGrant;
	modport seq  (input start, ready, holdReq, allow, output addrPhase, dataPhase, cycleDone, holdGrant);
	modport ctrl (output start, ready, holdReq, allow, input addrPhase, dataPhase, cycleDone, holdGrant);
endinterface

// File: bus_phase_seq.sv
// bus cycle phase sequencer: idle, address phase, data phase
module bus_phase_seq
	import cpu_pin_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// phase handshake
	bus_phase_if.seq  bp
);
	bus_state_t stateReg;
	bus_state_t stateNext;

	always_comb begin
		stateNext = stateReg;
		unique case (stateReg)
			BUS_IDLE: begin
				// a cycle always opens with its address phase
				if (bp.start && bp.allow && !bp.holdReq) begin
					stateNext = BUS_ADDR;
				end
			end
			BUS_ADDR: begin
				stateNext = BUS_DATA;
			end
			BUS_DATA: begin
				if (bp.ready) begin
					stateNext = BUS_IDLE;
				end
			end
		endcase
	end

	// async reset drops any cycle in flight
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stateReg <= BUS_IDLE;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign bp.addrPhase = (stateReg == BUS_ADDR);
	assign bp.dataPhase = (stateReg == BUS_DATA);
	assign bp.cycleDone = (stateReg == BUS_DATA) && bp.ready;
	// hold is only granted between cycles, never inside one
	assign bp.holdGrant = (stateReg == BUS_IDLE) && bp.holdReq;
endmodule

// File: cpu_pin_consts.svh
// constants for the processor pin-level bus and reset control block
`ifndef CPU_PIN_CONSTS_SVH
`define CPU_PIN_CONSTS_SVH
`define RESET_VECTOR   20'hFFFF0
`define NMI_TYPE       8'h02
`define ADDR_W         20
`define DATA_W         16
`define MID_SEL_W      4
`define HS_W           3
`endif

// File: cpu_pin_ctrl.sv
// pin-level bus, clock, reset, interrupt and mode control of the processor
`include "cpu_pin_consts.svh"
module cpu_pin_ctrl
	import cpu_pin_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset,
	// clock pins
	output logic                   clkRefOut,
	output logic                   crystalDriveOe,
	// reset indication
	output logic                   resetIndOut,
	output logic                   resetIndOe,
	// strap and select pins
	input  wire logic              narrowBus,
	input  wire logic              upperMemSelIn,
	input  wire logic              lowerMemSelIn,
	// core bus request
	input  wire logic              coreReq,
	input  wire cpu_pin_pkg::addr_t coreAddr,
	input  wire logic              coreWrite,
	input  wire logic              coreDmaCycle,
	input  wire cpu_pin_pkg::data_t coreWdata,
	input  wire logic              busReady,
	output logic                   coreDone,
	output cpu_pin_pkg::data_t     coreRdata,
	output logic                   bootFetch,
	// multiplexed bus pins
	input  wire cpu_pin_pkg::data_t sharedAdIn,
	output cpu_pin_pkg::data_t     sharedAdOut,
	output logic                   sharedAdOe,
	output logic [2:0]             upperAddrOut,
	output logic                   addr19Out,
	output logic                   upperAddrOe,
	output logic                   addrStrobe,
	// bus hold
	input  wire logic              holdReq,
	output logic                   holdAck,
	// non-maskable interrupt
	input  wire logic              nmiIn,
	input  wire logic              nmiTaken,
	output logic                   nmiPending,
	output logic [7:0]             nmiType,
	// wait/busy pin and coprocessor
	input  wire logic              waitBusyIn,
	input  wire logic              waitInstr,
	output logic                   execSuspend,
	output logic                   coprocMode,
	output logic                   coprocBusy,
	// midrange selects and coprocessor handshake
	input  wire cpu_pin_pkg::mid_sel_t midSelCore,
	input  wire cpu_pin_pkg::hs_t  coprocHsCore,
	output cpu_pin_pkg::mid_sel_t  midSelOut,
	output logic                   midSelOe,
	// powerdown
	input  wire logic              powerdownReq,
	input  wire logic              wakeReq,
	input  wire logic              pdTimerIn,
	output logic                   pdTimerOut,
	output logic                   pdTimerOe,
	output logic                   poweredDown
);
	import cpu_pin_pkg::*;

	bus_phase_if bp ();

	bus_phase_seq u_seq (
		.sys_clk (sys_clk),
		.reset   (reset),
		.bp      (bp.seq)
	);

	// reference clock on the falling edge; held low in reset so it restarts in phase
	logic clkRef_reg;
	logic clkRef_next;
	always_comb begin
		// divide by two, one toggle per falling edge
		clkRef_next = ~clkRef_reg;
	end
	// reset forces the phase, so release resynchronizes it
	always_ff @(negedge sys_clk or posedge reset) begin
		if (reset) begin
			clkRef_reg <= 1'b0;
		end else begin
			clkRef_reg <= clkRef_next;
		end
	end
	assign clkRefOut = clkRef_reg;

	// isolation strap has no async reset: it must see the select pins while reset is high
	logic isolate_reg;
	logic isolate_next;
	always_comb begin
		isolate_next = isolate_reg;
		// both selects low during reset floats the bus, reset indication, select and timer pins; crystal drive and reference clock stay driven
		if (reset) begin
			isolate_next = ~upperMemSelIn & ~lowerMemSelIn;
		end
	end
	always_ff @(posedge sys_clk) begin
		isolate_reg <= isolate_next;
	end

	// straps caught at the first edge after release, while the reset output is still high
	logic resetInd_reg, resetInd_next;
	logic coproc_reg, coproc_next;
	logic narrow_reg, narrow_next;
	logic boot_reg, boot_next;
	always_comb begin
		// reset output follows the reset input
		resetInd_next = 1'b0;
		coproc_next   = coproc_reg;
		narrow_next   = narrow_reg;
		boot_next     = boot_reg;
		if (resetInd_reg) begin
			// a wait/busy pin tied to reset output reads high here
			coproc_next = waitBusyIn;
			narrow_next = narrowBus;
		end
		// first cycle after reset fetches from the reset vector
		if (bp.addrPhase) begin
			boot_next = 1'b0;
		end
	end
	// reset sets every control flop to its initial state
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			resetInd_reg <= 1'b1;
			coproc_reg   <= 1'b0;
			narrow_reg   <= 1'b0;
			boot_reg     <= 1'b1;
		end else begin
			resetInd_reg <= resetInd_next;
			coproc_reg   <= coproc_next;
			narrow_reg   <= narrow_next;
			boot_reg     <= boot_next;
		end
	end

	// powerdown sequencing
	pwr_state_t pwr_reg;
	pwr_state_t pwr_next;
	always_comb begin
		pwr_next = pwr_reg;
		unique case (pwr_reg)
			PWR_RUN: begin
				if (powerdownReq && !bp.addrPhase && !bp.dataPhase) begin
					pwr_next = PWR_DOWN;
				end
			end
			PWR_DOWN: begin
				if (wakeReq) begin
					pwr_next = PWR_WAKE;
				end
			end
			PWR_WAKE: begin
				// resume only once the timer capacitor has charged
				if (pdTimerIn) begin
					pwr_next = PWR_RUN;
				end
			end
		endcase
	end

	// nmi: two-flop synchroniser, then edge detect on the settled copy
	logic [2:0] nmiSync_reg, nmiSync_next;
	logic       nmiPend_reg, nmiPend_next;
	always_comb begin
		nmiSync_next = {nmiSync_reg[1:0], nmiIn};
		nmiPend_next = nmiPend_reg;
		if (nmiTaken) begin
			nmiPend_next = 1'b0;
		end
		// a new rising edge wins over the clear in the same cycle
		if (nmiSync_reg[1] && !nmiSync_reg[2]) begin
			nmiPend_next = 1'b1;
		end
	end

	// latched request and pin outputs
	addr_t    addr_reg, addr_next;
	data_t    wdata_reg, wdata_next;
	logic     write_reg, write_next;
	logic     dma_reg, dma_next;
	data_t    adOut_reg, adOut_next;
	logic     adOe_reg, adOe_next;
	logic [2:0] upAddr_reg, upAddr_next;
	logic     a19_reg, a19_next;
	logic     upOe_reg, upOe_next;
	logic     strobe_reg, strobe_next;
	logic     done_reg, done_next;
	data_t    rdata_reg, rdata_next;
	logic     hold_reg, hold_next;
	logic     susp_reg, susp_next;
	logic     busy_reg, busy_next;
	mid_sel_t mid_reg, mid_next;
	logic     pdOut_reg, pdOut_next;
	logic     pdOe_reg, pdOe_next;
	logic     running;

	assign running    = (pwr_reg == PWR_RUN);
	assign bp.start   = coreReq;
	assign bp.ready   = busReady;
	assign bp.holdReq = holdReq;
	assign bp.allow   = running;

	always_comb begin
		addr_next   = addr_reg;
		wdata_next  = wdata_reg;
		write_next  = write_reg;
		dma_next    = dma_reg;
		adOut_next  = adOut_reg;
		adOe_next   = adOe_reg;
		upAddr_next = upAddr_reg;
		a19_next    = a19_reg;
		upOe_next   = upOe_reg;
		strobe_next = 1'b0;
		done_next   = bp.cycleDone;
		rdata_next  = rdata_reg;
		hold_next   = bp.holdGrant;
		if (bp.start && !bp.addrPhase && !bp.dataPhase) begin
			addr_next  = boot_reg ? `RESET_VECTOR : coreAddr;
			wdata_next = coreWdata;
			write_next = coreWrite;
			dma_next   = coreDmaCycle;
		end
		if (bp.addrPhase) begin
			// low address on the shared pins, latched by the strobe
			adOut_next  = addr_reg[15:0];
			adOe_next   = 1'b1;
			// upper address bits in the address phase
			upAddr_next = addr_reg[18:16];
			a19_next    = addr_reg[19];
			upOe_next   = 1'b1;
			strobe_next = 1'b1;
		end else if (bp.dataPhase) begin
			// data phase: drive write data, release for reads
			adOut_next  = wdata_reg;
			adOe_next   = write_reg;
			if (narrow_reg) begin
				// narrow bus keeps address 15..8 for the whole cycle
				adOut_next[15:8] = addr_reg[15:8];
				adOe_next        = 1'b1;
			end
			// bits 18..16 go to zero in the data phase
			upAddr_next = 3'h0;
			// cycle source on the bit-19 pin
			a19_next    = dma_reg;
			upOe_next   = 1'b1;
			if (bus_phase_done(busReady, write_reg)) begin
				rdata_next = sharedAdIn;
			end
		end else if (running) begin
			// idle or hold: float the bus pins
			adOe_next = 1'b0;
			upOe_next = 1'b0;
		end
		// powerdown leaves values and enables untouched
		if (isolate_reg) begin
			adOe_next = 1'b0;
			upOe_next = 1'b0;
		end
		// regular mode: WAIT stalls while the pin is high
		susp_next = waitInstr && !coproc_reg && waitBusyIn;
		// coprocessor mode: pin reports coprocessor activity
		busy_next = coproc_reg && waitBusyIn;
		mid_next  = midSelCore;
		if (coproc_reg) begin
			// selects 0, 1 and 3 become coprocessor handshake
			mid_next[0] = coprocHsCore[0];
			mid_next[1] = coprocHsCore[1];
			mid_next[3] = coprocHsCore[2];
		end
		// timer pin: driven high in powerdown unless isolated, released otherwise
		pdOut_next = 1'b1;
		pdOe_next  = (pwr_next == PWR_DOWN) && !isolate_reg;
	end

	// read data is captured on the final data-phase edge of a read
	function automatic logic bus_phase_done(input logic rdy, input logic wr);
		bus_phase_done = rdy && !wr;
	endfunction

	// reset floats the bus and defines every pin
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pwr_reg     <= PWR_RUN;
			nmiSync_reg <= 3'h0;
			nmiPend_reg <= 1'b0;
			addr_reg    <= 20'h00000;
			wdata_reg   <= 16'h0000;
			write_reg   <= 1'b0;
			dma_reg     <= 1'b0;
			adOut_reg   <= 16'h0000;
			adOe_reg    <= 1'b0;
			upAddr_reg  <= 3'h0;
			a19_reg     <= 1'b0;
			upOe_reg    <= 1'b0;
			strobe_reg  <= 1'b0;
			done_reg    <= 1'b0;
			rdata_reg   <= 16'h0000;
			hold_reg    <= 1'b0;
			susp_reg    <= 1'b0;
			busy_reg    <= 1'b0;
			mid_reg     <= 4'hF;
			pdOut_reg   <= 1'b0;
			pdOe_reg    <= 1'b0;
		end else begin
			pwr_reg     <= pwr_next;
			nmiSync_reg <= nmiSync_next;
			nmiPend_reg <= nmiPend_next;
			addr_reg    <= addr_next;
			wdata_reg   <= wdata_next;
			write_reg   <= write_next;
			dma_reg     <= dma_next;
			adOut_reg   <= adOut_next;
			adOe_reg    <= adOe_next;
			upAddr_reg  <= upAddr_next;
			a19_reg     <= a19_next;
			upOe_reg    <= upOe_next;
			strobe_reg  <= strobe_next;
			done_reg    <= done_next;
			rdata_reg   <= rdata_next;
			hold_reg    <= hold_next;
			susp_reg    <= susp_next;
			busy_reg    <= busy_next;
			mid_reg     <= mid_next;
			pdOut_reg   <= pdOut_next;
			pdOe_reg    <= pdOe_next;
		end
	end

	// clock-related drivers never float, even when isolated
	assign crystalDriveOe = resetInd_reg | ~resetInd_reg;
	assign resetIndOut    = resetInd_reg;
	assign resetIndOe     = ~isolate_reg;
	assign coreDone       = done_reg;
	assign coreRdata      = rdata_reg;
	assign bootFetch      = boot_reg;
	assign sharedAdOut    = adOut_reg;
	assign sharedAdOe     = adOe_reg;
	assign upperAddrOut   = upAddr_reg;
	assign addr19Out      = a19_reg;
	assign upperAddrOe    = upOe_reg;
	assign addrStrobe     = strobe_reg;
	assign holdAck        = hold_reg;
	assign nmiPending     = nmiPend_reg;
	assign nmiType        = `NMI_TYPE;
	assign execSuspend    = susp_reg;
	assign coprocMode     = coproc_reg;
	assign coprocBusy     = busy_reg;
	assign midSelOut      = mid_reg;
	assign midSelOe       = ~isolate_reg;
	assign pdTimerOut     = pdOut_reg;
	assign pdTimerOe      = pdOe_reg;
	assign poweredDown    = ~running;
endmodule

// File: cpu_pin_ctrl_chk.sv
// concurrent checks on the pin controller ports
module cpu_pin_ctrl_chk (
	// clock and reset
	input wire logic               sys_clk,
	input wire logic               reset,
	// watched pins
	input wire logic               clkRefOut,
	input wire logic               crystalDriveOe,
	input wire logic               resetIndOut,
	input wire logic               coprocMode,
	input wire logic               addrStrobe,
	input wire logic [2:0]         upperAddrOut,
	input wire logic               upperAddrOe,
	input wire cpu_pin_pkg::data_t sharedAdOut,
	input wire logic               sharedAdOe,
	input wire logic               holdAck,
	input wire logic               busReady,
	input wire logic               coreDone,
	input wire logic               nmiIn,
	input wire logic               nmiPending,
	input wire logic               poweredDown
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	clk_toggle_a: assert property (!$past(reset) && !poweredDown |-> clkRefOut != $past(clkRefOut))
		else $error("reference clock did not toggle");
	osc_drive_a: assert property (crystalDriveOe)
		else $error("crystal drive released");
	rst_hold_a: assert property ($fell(reset) |-> resetIndOut)
		else $error("reset indication dropped early");
	rst_end_a: assert property (!$past(reset) |-> !resetIndOut)
		else $error("reset indication stuck");
	mode_stable_a: assert property (!$past(reset, 2) |-> $stable(coprocMode))
		else $error("mode changed outside reset");
	data_phase_a: assert property (addrStrobe |=> upperAddrOut == 3'h0 && upperAddrOe)
		else $error("upper address not zero in data phase");
	done_ready_a: assert property (coreDone |-> $past(busReady) && !$past(coreDone))
		else $error("done without ready");
	nmi_latch_a: assert property ($rose(nmiIn) |-> ##[1:4] nmiPending)
		else $error("nmi not latched");
	hold_float_a: assert property (holdAck && $past(holdAck) |-> !sharedAdOe && !upperAddrOe)
		else $error("bus driven in hold");
	pd_hold_a: assert property (poweredDown && $past(poweredDown) |-> $stable(sharedAdOut) && $stable(sharedAdOe))
		else $error("bus moved in powerdown");
endmodule
bind cpu_pin_ctrl cpu_pin_ctrl_chk u_chk (.sys_clk, .reset, .clkRefOut, .crystalDriveOe, .resetIndOut, .coprocMode,
	.addrStrobe, .upperAddrOut, .upperAddrOe, .sharedAdOut, .sharedAdOe, .holdAck, .busReady, .coreDone, .nmiIn,
	.nmiPending, .poweredDown);

// File: cpu_pin_pkg.sv
// shared types for the pin-level control block
`include "cpu_pin_consts.svh"
package cpu_pin_pkg;
	typedef logic [`ADDR_W-1:0]    addr_t;
	typedef logic [`DATA_W-1:0]    data_t;
	typedef logic [`MID_SEL_W-1:0] mid_sel_t;
	typedef logic [`HS_W-1:0]      hs_t;
	typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA} bus_state_t;
	typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_WAKE} pwr_state_t;
endpackage

// File: tb.sv
// self-checking bench for the pin controller
`define CK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cpu_pin_pkg::*;
	logic sys_clk, reset, clkRefOut, crystalDriveOe, resetIndOut, resetIndOe, narrowBus, upperMemSelIn, lowerMemSelIn;
	logic coreReq, coreWrite, coreDmaCycle, busReady, coreDone, bootFetch, sharedAdOe, addr19Out, upperAddrOe;
	logic addrStrobe, holdReq, holdAck, nmiIn, nmiTaken, nmiPending, waitBusyIn, waitInstr, execSuspend;
	logic coprocMode, coprocBusy, midSelOe, powerdownReq, wakeReq, pdTimerIn, pdTimerOut, pdTimerOe, poweredDown;
	logic slow, tie, busy, nb;
	addr_t coreAddr;
	data_t coreWdata, coreRdata, sharedAdIn, sharedAdOut;
	logic [2:0] upperAddrOut;
	logic [7:0] nmiType;
	mid_sel_t midSelCore, midSelOut;
	hs_t coprocHsCore;
	int fail_count, check_count, cycles;
	// tie the wait/busy pin to the reset indication to pick coprocessor mode
	assign waitBusyIn = tie ? resetIndOut : busy;
	cpu_pin_ctrl u_cpu_pin_ctrl (.sys_clk, .reset, .clkRefOut, .crystalDriveOe, .resetIndOut, .resetIndOe, .narrowBus,
		.upperMemSelIn, .lowerMemSelIn, .coreReq, .coreAddr, .coreWrite, .coreDmaCycle, .coreWdata, .busReady,
		.coreDone, .coreRdata, .bootFetch, .sharedAdIn, .sharedAdOut, .sharedAdOe, .upperAddrOut, .addr19Out,
		.upperAddrOe, .addrStrobe, .holdReq, .holdAck, .nmiIn, .nmiTaken, .nmiPending, .nmiType, .waitBusyIn,
		.waitInstr, .execSuspend, .coprocMode, .coprocBusy, .midSelCore, .coprocHsCore, .midSelOut, .midSelOe,
		.powerdownReq, .wakeReq, .pdTimerIn, .pdTimerOut, .pdTimerOe, .poweredDown);
	bus_partner u_bus_partner (.sys_clk, .sharedAdOut, .addrStrobe, .slow, .sharedAdIn, .busReady);
	// input clock at twice the processor rate
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rst(input logic n, t, iso);
		nb = n;
		narrowBus = n;
		tie = t;
		{upperMemSelIn, lowerMemSelIn} = iso ? 2'h0 : 2'h3;
		reset = 1'b1;
		coreReq = 1'b0;
		repeat (6) @(negedge sys_clk);
		`CK("resetInd", 1'b1, resetIndOut)
		`CK("adOe", 1'b0, sharedAdOe)
		`CK("clkRef", 1'b0, clkRefOut)
		`CK("upOe", 1'b0, upperAddrOe)
		// released by nonblocking write: the reference clock flop also acts on this falling edge
		reset <= 1'b0;
		@(negedge sys_clk);
		tie = 1'b0;
		{upperMemSelIn, lowerMemSelIn} = 2'h3;
		repeat (2) @(negedge sys_clk);
		`CK("crystalOe", 1'b1, crystalDriveOe)
		`CK("mode", t, coprocMode)
		`CK("isolate", iso, !midSelOe)
		`CK("resIndOe", !iso, resetIndOe)
	endtask
	task automatic bus(input addr_t a, input logic w, d, input data_t wd, input addr_t ea);
		int n;
		n = 0;
		{coreAddr, coreWrite, coreDmaCycle, coreWdata, coreReq} = {a, w, d, wd, 1'b1};
		while (addrStrobe !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		`CK("adLow", ea[15:0], sharedAdOut)
		`CK("adHigh", ea[19:16], {addr19Out, upperAddrOut})
		@(negedge sys_clk);
		`CK("a18to16", 3'h0, upperAddrOut)
		`CK("source", d, addr19Out)
		if (w && !nb) `CK("wdata", wd, sharedAdOut)
		if (nb) `CK("narrowHi", ea[15:8], sharedAdOut[15:8])
		while (coreDone !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		coreReq = 1'b0;
		`CK("done", 1'b1, coreDone)
		if (!w && !nb) `CK("rdata", ea[15:0] ^ 16'hA5C3, coreRdata)
		// let an edge pass so the next request is not raised in the step that lowered this one
		@(negedge sys_clk);
	endtask
	task automatic t_cycles();
		`CK("boot", 1'b1, bootFetch)
		bus(20'h12345, 1'b0, 1'b0, 16'h0000, 20'hFFFF0);
		`CK("bootEnd", 1'b0, bootFetch)
		bus(20'hF1234, 1'b1, 1'b0, 16'h55AA, 20'hF1234);
		slow = 1'b1;
		bus(20'h8BEEF, 1'b0, 1'b1, 16'h0000, 20'h8BEEF);
		bus(20'h70001, 1'b1, 1'b1, 16'hC3E1, 20'h70001);
		slow = 1'b0;
		$display("test cycles done");
	endtask
	task automatic t_misc();
		holdReq = 1'b1;
		repeat (3) @(negedge sys_clk);
		`CK("holdAck", 1'b1, holdAck)
		`CK("holdAdOe", 1'b0, sharedAdOe)
		holdReq = 1'b0;
		nmiIn = 1'b1;
		repeat (5) @(negedge sys_clk);
		`CK("nmi", 1'b1, nmiPending)
		`CK("nmiType", 8'h02, nmiType)
		{nmiIn, nmiTaken} = 2'h1;
		@(negedge sys_clk);
		nmiTaken = 1'b0;
		@(negedge sys_clk);
		`CK("nmiClr", 1'b0, nmiPending)
		{waitInstr, busy} = 2'h3;
		repeat (3) @(negedge sys_clk);
		`CK("suspend", 1'b1, execSuspend)
		busy = 1'b0;
		repeat (3) @(negedge sys_clk);
		`CK("resume", 1'b0, execSuspend)
		waitInstr = 1'b0;
		$display("test hold nmi wait done");
	endtask
	task automatic t_power();
		powerdownReq = 1'b1;
		repeat (2) @(negedge sys_clk);
		powerdownReq = 1'b0;
		`CK("down", 1'b1, poweredDown)
		`CK("pdOe", 1'b1, pdTimerOe)
		`CK("pdOut", 1'b1, pdTimerOut)
		{wakeReq, pdTimerIn, coreReq} = 3'h5;
		repeat (6) begin
			@(negedge sys_clk);
			`CK("noStart", 1'b0, addrStrobe)
		end
		`CK("pdRel", 1'b0, pdTimerOe)
		{wakeReq, pdTimerIn} = 2'h1;
		bus(20'h0ABCD, 1'b0, 1'b0, 16'h0000, 20'h0ABCD);
		$display("test powerdown done");
	endtask
	task automatic t_straps();
		coreReq = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst(1'b1, 1'b0, 1'b0);
		bus(20'h3C5A7, 1'b1, 1'b0, 16'h0011, 20'hFFFF0);
		rst(1'b0, 1'b1, 1'b0);
		busy = 1'b1;
		repeat (3) @(negedge sys_clk);
		`CK("cpBusy", 1'b1, coprocBusy)
		`CK("handshake", 4'h9, midSelOut)
		busy = 1'b0;
		repeat (3) @(negedge sys_clk);
		`CK("cpIdle", 1'b0, coprocBusy)
		rst(1'b0, 1'b0, 1'b1);
		$display("test straps done");
	endtask
	initial begin
		// reset, straps and the request line are first set by rst
		{sys_clk, slow, busy, holdReq, nmiIn, nmiTaken, waitInstr} = 7'h00;
		{powerdownReq, wakeReq, pdTimerIn, coreWrite, coreDmaCycle} = 5'h00;
		coreAddr = 20'h00000;
		coreWdata = 16'h0000;
		midSelCore = 4'h0;
		coprocHsCore = 3'h5;
		fail_count = 0;
		check_count = 0;
		cycles = 0;
		rst(1'b0, 1'b0, 1'b0);
		t_cycles();
		t_misc();
		t_power();
		t_straps();
		conclude();
	end
endmodule
